//--- hdl/adc_port_defs.vh
// Constants for the converter serial port and result-ready logic
`ifndef ADC_PORT_DEFS_VH
`define ADC_PORT_DEFS_VH

// Register select codes in the communications word
`define RSEL_COMM 3'h0
`define RSEL_SETUP 3'h1
`define RSEL_CLOCK 3'h2
`define RSEL_DATA 3'h3

// Communications word field positions
`define COMM_ZERO_BIT 7
`define COMM_RSEL_HI 6
`define COMM_RSEL_LO 4
`define COMM_READ_BIT 3
`define COMM_STBY_BIT 2

// Register widths in bits
`define CTRL_BITS 5'h08
`define DATA_BITS 5'h10

// Reset values
`define COMM_RESET 8'h00
`define SETUP_RESET 8'h00
`define CLOCK_RESET 8'h00
`define DATA_RESET 16'h0000

// Master-clock periods that ready stays high ahead of an update
`define READY_HOLD_CYCLES 500

// Result buffer shape
`define FIFO_WIDTH 16
`define FIFO_DEPTH 16

`endif

//--- hdl/word_fifo.v
// Synchronous word FIFO with valid/ready on both sides
`default_nettype none

module word_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter ADDR_W = 4
) (
    // Clock and reset
    input wire clock_i,
    input wire reset_n_i,
    // Filling side
    input wire in_valid_i,
    output reg in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Draining side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    // Storage array
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    // Read and write pointers
    reg [ADDR_W-1:0] wr_ptr;
    reg [ADDR_W-1:0] rd_ptr;
    // Words held
    reg [ADDR_W:0] count;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    wire [ADDR_W:0] next_count = count + {{ADDR_W{1'b0}}, push} - {{ADDR_W{1'b0}}, pop};

    assign out_valid_o = (count != {(ADDR_W+1){1'b0}});
    assign out_data_o = mem[rd_ptr];

    // Array write, no reset needed
    always @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers, count and registered ready
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr <= {ADDR_W{1'b0}};
            rd_ptr <= {ADDR_W{1'b0}};
            count <= {(ADDR_W+1){1'b0}};
            in_ready_o <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : rd_ptr + 1'b1;
            end
            count <= next_count;
            // Full shows one cycle after the last push, never overflows
            in_ready_o <= (next_count != DEPTH[ADDR_W:0]);
        end
    end
endmodule

`default_nettype wire

//--- hdl/adc_serial_port.v
// Serial register port and result-ready signalling of the converter
`include "adc_port_defs.vh"
`default_nettype none

// How the port behaves, in short:
// The host clocks a command byte, then one operation word. A read
// returns the register that the command selects, most significant
// bit first; a write lands in setup, clock or communications.
// The data register word is 16 bits and cannot be written: a
// write to it is clocked in at full width and then discarded.
// Host pins pass two flops, so each serial clock phase must last
// several master clocks; a whole data read must also fit inside the hold period.
// A command byte with its top bit set is dropped, so a host that
// lost framing can clock ones until it is back in step.
// Deselecting mid-operation only restarts the bit count; the
// pending operation still waits for its full word.
// An unread result is replaced only after ready has been high for
// the hold period, so a host polling ready never reads mid-update.
module adc_serial_port #(
    parameter WORD_W = `FIFO_WIDTH,
    parameter DEPTH = `FIFO_DEPTH,
    parameter ADDR_W = 4,
    parameter HOLD_CYCLES = `READY_HOLD_CYCLES
) (
    // Master clock and reset
    input wire clock_i,
    input wire reset_n_i,
    // Serial pins from the host
    input wire sclk_i,
    input wire cs_n_i,
    input wire din_i,
    // Serial pins to the host
    output reg dout_o,
    output reg result_ready_n_o,
    // Conversion results from the filter
    input wire sample_valid_i,
    output wire sample_ready_o,
    input wire [WORD_W-1:0] sample_data_i,
    // Calibration finished pulse
    input wire cal_done_i,
    // Control registers towards the converter core
    output reg [7:0] setup_o,
    output reg [7:0] clock_o,
    output reg standby_o
);
    // Update sequencer states
    // Idle waits for a buffered word; hold keeps ready high first
    localparam UPD_IDLE = 1'b0;
    localparam UPD_HOLD = 1'b1;
    // Port phases: waiting for a command, or doing one
    localparam PH_CMD = 1'b0;
    localparam PH_OP = 1'b1;

    // Bit count of the register picked by a select code
    function [4:0] reg_bits;
        input [2:0] rsel;
        begin
            reg_bits = (rsel == `RSEL_DATA) ? `DATA_BITS : `CTRL_BITS;
        end
    endfunction

    // Synchroniser stages for the host pins
    reg sclk_s1, sclk_s2, sclk_s3;
    reg cs_s1, cs_s2;
    reg din_s1, din_s2;
    // Communications register
    reg [7:0] comm;
    // Data register holding the latest result
    reg [WORD_W-1:0] data_reg;
    // Result not yet read by the host
    // Decides whether the next update needs the ready hold
    reg data_unread;
    // Shift registers and bit counter
    reg [15:0] in_shift;
    reg [15:0] out_shift;
    reg [4:0] bit_cnt;
    reg phase;
    // Update sequencer
    reg upd_state;
    // Hold counter, wide enough for the default hold length
    reg [9:0] hold_cnt;
    // Buffer draining side
    wire fifo_valid;
    wire [WORD_W-1:0] fifo_data;
    reg load_data;

    // Register fields of the current command
    wire [2:0] cur_rsel = comm[`COMM_RSEL_HI:`COMM_RSEL_LO];
    wire cur_read = comm[`COMM_READ_BIT];
    wire [4:0] cur_bits = reg_bits(cur_rsel);
    // Edges seen only while selected
    wire selected = ~cs_s2;
    wire sclk_rise = selected & sclk_s2 & ~sclk_s3;
    wire sclk_fall = selected & ~sclk_s2 & sclk_s3;
    // A data read is under way
    wire reading_data = (phase == PH_OP) & cur_read & (cur_rsel == `RSEL_DATA);
    // Last bit of a word arrives on this edge
    wire cmd_done = sclk_rise & (phase == PH_CMD) & (bit_cnt == `CTRL_BITS - 5'h01);
    wire op_done = sclk_rise & (phase == PH_OP) & (bit_cnt == cur_bits - 5'h01);
    wire data_read_done = op_done & reading_data;
    // Received command word including the bit on this edge
    wire [7:0] cmd_word = {in_shift[6:0], din_s2};

    // Result buffer between the filter and the data register
    word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(DEPTH),
        .ADDR_W(ADDR_W)
    ) result_fifo (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(sample_valid_i),
        .in_ready_o(sample_ready_o),
        .in_data_i(sample_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(load_data),
        .out_data_o(fifo_data)
    );

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_s1 <= 1'b1;
            sclk_s2 <= 1'b1;
            sclk_s3 <= 1'b1;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
        end else begin
            // Pins are asynchronous; two flops before any logic reads them
            sclk_s1 <= sclk_i;
            sclk_s2 <= sclk_s1;
            // Edge reference, reads only the settled stage
            sclk_s3 <= sclk_s2;
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            din_s1 <= din_i;
            din_s2 <= din_s1;
        end
    end

    // Serial framing, command decode and register writes
    // Deselect restarts the bit count only; a pending operation survives
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            comm <= `COMM_RESET;
            setup_o <= `SETUP_RESET;
            clock_o <= `CLOCK_RESET;
            standby_o <= 1'b0;
            in_shift <= 16'h0000;
            bit_cnt <= 5'h00;
            phase <= PH_CMD;
        end else if (!selected) begin
            bit_cnt <= 5'h00;
        end else if (sclk_rise) begin
            // Host drives data for sampling on the rising edge
            in_shift <= {in_shift[14:0], din_s2};
            if (cmd_done) begin
                bit_cnt <= 5'h00;
                // A command must start with a zero bit, else keep waiting
                if (!cmd_word[`COMM_ZERO_BIT]) begin
                    comm <= cmd_word;
                    // Standby follows every accepted command byte
                    standby_o <= cmd_word[`COMM_STBY_BIT];
                    phase <= PH_OP;
                end
            end else if (op_done) begin
                bit_cnt <= 5'h00;
                phase <= PH_CMD;
                if (!cur_read) begin
                    case (cur_rsel)
                        `RSEL_COMM: begin
                            comm <= {1'b0, cmd_word[6:0]};
                            // A direct comms write also sets standby
                            standby_o <= cmd_word[`COMM_STBY_BIT];
                        end
                        `RSEL_SETUP: begin
                            setup_o <= cmd_word;
                        end
                        `RSEL_CLOCK: begin
                            clock_o <= cmd_word;
                        end
                        default: begin
                            // Data register and unused codes ignore writes
                        end
                    endcase
                end
            end else begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // Output shift register, loaded as a read command completes
    // Loading on the last command edge leaves half a clock before bit one
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_shift <= 16'h0000;
            dout_o <= 1'b1;
        end else if (cmd_done && !cmd_word[`COMM_ZERO_BIT] && cmd_word[`COMM_READ_BIT]) begin
            case (cmd_word[`COMM_RSEL_HI:`COMM_RSEL_LO])
                `RSEL_COMM: begin
                    // Comms readback shows ready in bit 7 over the command byte just received
                    out_shift <= {result_ready_n_o, cmd_word[6:0], 8'h00};
                end
                `RSEL_SETUP: begin
                    out_shift <= {setup_o, 8'h00};
                end
                `RSEL_CLOCK: begin
                    out_shift <= {clock_o, 8'h00};
                end
                `RSEL_DATA: begin
                    out_shift <= data_reg;
                end
                default: begin
                    out_shift <= 16'h0000;
                end
            endcase
        end else if (sclk_fall && phase == PH_OP && cur_read) begin
            // next bit out on the falling edge
            dout_o <= out_shift[15];
            out_shift <= {out_shift[14:0], 1'b0};
        end else if (!selected) begin
            // Idle level between frames
            dout_o <= 1'b1;
        end
    end

    // Update sequencer moving buffered results into the data register
    // A running data read stalls a load from idle; the load that ends a hold goes ahead
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            upd_state <= UPD_IDLE;
            hold_cnt <= 10'h000;
            load_data <= 1'b0;
            data_reg <= `DATA_RESET;
        end else begin
            load_data <= 1'b0;
            case (upd_state)
                UPD_IDLE: begin
                    // wait while a data read runs
                    if (fifo_valid && !load_data && !reading_data) begin
                        if (data_unread) begin
                            upd_state <= UPD_HOLD;
                            hold_cnt <= 10'h000;
                        end else begin
                            data_reg <= fifo_data;
                            load_data <= 1'b1;
                        end
                    end
                end
                UPD_HOLD: begin
                    // count the hold period
                    // Data lands on the last hold cycle, ready falls one later
                    if (hold_cnt == HOLD_CYCLES[9:0] - 10'h001) begin
                        upd_state <= UPD_IDLE;
                        data_reg <= fifo_data;
                        load_data <= 1'b1;
                    end else begin
                        hold_cnt <= hold_cnt + 10'h001;
                    end
                end
                default: begin
                    upd_state <= UPD_IDLE;
                end
            endcase
        end
    end

    // Ready output; later assignments win, so new data beats a clear
    // Calibration end shows as ready low without marking data unread
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            result_ready_n_o <= 1'b1;
            data_unread <= 1'b0;
        end else begin
            if (data_read_done) begin
                result_ready_n_o <= 1'b1;
                data_unread <= 1'b0;
            end
            // Same condition the sequencer uses to enter the hold
            if (upd_state == UPD_IDLE && fifo_valid && !load_data && !reading_data
                && data_unread) begin
                result_ready_n_o <= 1'b1;
            end
            if (cal_done_i) begin
                result_ready_n_o <= 1'b0;
            end
            if (load_data) begin
                result_ready_n_o <= 1'b0;
                data_unread <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

//--- bench/adc_port_properties.sv
// Assertion checker for the converter serial port
`default_nettype none
module adc_port_properties #(parameter HOLD_CYCLES = 500) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic dout_o,
    input wire logic result_ready_n_o,
    // Result stream and control
    input wire logic sample_valid_i,
    input wire logic sample_ready_o,
    input wire logic cal_done_i,
    input wire logic [7:0] setup_o,
    input wire logic [7:0] clock_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOAD_MAX = HOLD_CYCLES + 4;
    logic [11:0] hi_cnt; // Length of the current high stretch of ready
    logic hold_flag; // Stretch began with the port idle, so it is an update hold
    // Measure high stretches of ready
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hi_cnt <= 12'h000;
            hold_flag <= 1'b0;
        end else begin
            hi_cnt <= result_ready_n_o ? hi_cnt + 12'h001 : 12'h000;
            if (!result_ready_n_o)
                hold_flag <= 1'b0;
            else if ($rose(result_ready_n_o) && cs_n_i && $past(cs_n_i, 8))
                hold_flag <= 1'b1;
        end
    end
    sequence s_push_waiting;
        sample_valid_i && sample_ready_o && result_ready_n_o && cs_n_i;
    endsequence
    sequence s_hold_end;
        $fell(result_ready_n_o) && hold_flag;
    endsequence
    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    a_push_sets_ready: assert property (s_push_waiting |-> ##[1:LOAD_MAX] !result_ready_n_o)
        else $error("ready not low after new word");
    a_hold_exact_length: assert property (s_hold_end |-> hi_cnt >= HOLD_CYCLES && hi_cnt <= HOLD_CYCLES + 3)
        else $error("update hold has wrong length");
    a_hold_ends_bounded: assert property (hold_flag && result_ready_n_o |-> hi_cnt <= HOLD_CYCLES + 3)
        else $error("ready stuck high after hold");
    a_cal_ready_low: assert property (cal_done_i |=> !result_ready_n_o)
        else $error("calibration end not shown");
    a_dout_idle_high: assert property (cs_n_i [*5] |-> dout_o)
        else $error("dout not high while deselected");
    a_dout_on_fall: assert property ($changed(dout_o) && !cs_n_i && !$past(cs_n_i, 6) |-> !$past(sclk_i, 2))
        else $error("dout moved away from a falling serial clock");
    a_setup_when_selected: assert property (!$stable(setup_o) |-> !$past(cs_n_i, 3))
        else $error("setup changed while deselected");
    a_clock_when_selected: assert property ($changed(clock_o) |-> $past(!cs_n_i, 3))
        else $error("clock register changed while deselected");
    a_full_needs_push: assert property ($fell(sample_ready_o) |-> $past(sample_valid_i))
        else $error("buffer refused without a push");
endmodule
bind adc_serial_port adc_port_properties #(.HOLD_CYCLES(HOLD_CYCLES)) props_i (.clock_i, .reset_n_i,
    .sclk_i, .cs_n_i, .dout_o, .result_ready_n_o, .sample_valid_i, .sample_ready_o, .cal_done_i,
    .setup_o, .clock_o);
`default_nettype wire

//--- bench/host_port_model.sv
// Host serial controller model driving the converter port
`default_nettype none
module host_port_model (
    // Serial pins towards the port
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    // Data from the port
    input wire logic dout_i
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam time HALF = 80ns; // Half of the 160 ns link clock
    // Link idles high and deselected
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    // one framed burst: command then n bits, MSB first
    task automatic frame(input logic [7:0] cmd, input int n, input logic [15:0] tx,
                         output logic [15:0] rx);
        logic [23:0] sh;
        sh = {cmd, tx << (16 - n)};
        rx = 16'h0000;
        // Deselect gap long enough for the synchroniser to see it
        #HALF;
        cs_n_o = 1'b0;
        #HALF;
        for (int i = 0; i < 8 + n; i++) begin
            sclk_o = 1'b0;
            din_o = sh[23 - i];
            #HALF;
            sclk_o = 1'b1;
            if (i >= 8)
                rx = {rx[14:0], dout_i};
            #HALF;
        end
        cs_n_o = 1'b1;
        // Released data line must not keep the last bit
        din_o = ~din_o;
    endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the converter serial port
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 600; // Lengthened hold, still longer than a command
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sample_valid_i = 1'b0;
    logic [15:0] sample_data_i = 16'h0000;
    logic cal_done_i = 1'b0;
    wire sclk, cs_n, din, dout, rdy_n, s_ready, standby;
    wire [7:0] setup, clk_reg;
    int errors = 0;
    int total_checks = 0;
    logic [15:0] rx;
    always #5 clock_i = ~clock_i;
    adc_serial_port #(.HOLD_CYCLES(HOLD)) adc_serial_port_i (.clock_i, .reset_n_i, .sclk_i(sclk),
        .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .result_ready_n_o(rdy_n), .sample_valid_i,
        .sample_ready_o(s_ready), .sample_data_i, .cal_done_i, .setup_o(setup),
        .clock_o(clk_reg), .standby_o(standby));
    host_port_model host_port_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Count cycles until ready shows a level, sampled mid-cycle
    task automatic wait_ready(input logic lvl, input int lim, output int n);
        n = 0;
        while (rdy_n !== lvl && n < lim) begin
            @(negedge clock_i);
            n++;
        end
    endtask
    task automatic push(input logic [15:0] d);
        @(posedge clock_i);
        sample_valid_i <= 1'b1;
        sample_data_i <= d;
        @(posedge clock_i);
        sample_valid_i <= 1'b0;
    endtask
    // data read only once ready is low
    task automatic read_data(input logic [15:0] exp);
        int n;
        wait_ready(1'b0, 3000, n);
        check(rdy_n, 1'b0, "ready low");
        host_port_model_i.frame(8'h38, 16, 16'h0000, rx);
        check(rx, exp, "data read");
        check(rdy_n, 1'b1, "ready after read");
    endtask
    // control writes, ignored data write, read back
    task automatic t_regs();
        check(dout, 1'b1, "idle dout");
        host_port_model_i.frame(8'h10, 8, 16'h00a5, rx);
        host_port_model_i.frame(8'h20, 8, 16'h003c, rx);
        // Data register write is a full 16-bit word that is dropped
        host_port_model_i.frame(8'h34, 16, 16'h00ff, rx);
        check(setup, 8'ha5, "setup write");
        check(clk_reg, 8'h3c, "clock write");
        check(standby, 1'b1, "standby bit");
        host_port_model_i.frame(8'h18, 8, 16'h0000, rx);
        check(rx, 16'h00a5, "setup read");
        host_port_model_i.frame(8'h28, 8, 16'h0000, rx);
        check(rx, 16'h003c, "clock read");
        host_port_model_i.frame(8'h00, 8, 16'h0004, rx);
        check(standby, 1'b1, "comm write");
        host_port_model_i.frame(8'h08, 8, 16'h0000, rx);
        check(rx, 16'h0088, "comm read");
    endtask
    // unread word replaced after the hold
    task automatic t_hold();
        int n;
        push(16'h5a5a);
        wait_ready(1'b0, 3000, n);
        push(16'hc3c3);
        wait_ready(1'b1, 3000, n);
        wait_ready(1'b0, 3000, n);
        check(n >= HOLD && n <= HOLD + 3, 1'b1, "hold length");
        read_data(16'hc3c3);
    endtask
    // buffer fills until refused, drains while host stalls
    task automatic t_fill();
        int n;
        int acc;
        @(posedge clock_i);
        sample_valid_i <= 1'b1;
        for (acc = 0; acc < 40; acc++) begin
            sample_data_i <= 16'h0100 + 16'(acc);
            @(negedge clock_i);
            if (s_ready !== 1'b1)
                break;
            @(posedge clock_i);
        end
        @(posedge clock_i);
        sample_valid_i <= 1'b0;
        check(acc >= 16 && acc <= 18, 1'b1, "buffer depth");
        for (int k = 0; k < 24; k++) begin
            wait_ready(1'b1, HOLD + 50, n);
            if (n >= HOLD + 50)
                break;
            wait_ready(1'b0, HOLD + 50, n);
        end
        check(s_ready, 1'b1, "buffer drained");
        read_data(16'h0100 + 16'(acc - 1));
    endtask
    task automatic t_cal();
        @(posedge clock_i);
        cal_done_i <= 1'b1;
        @(posedge clock_i);
        cal_done_i <= 1'b0;
        @(negedge clock_i);
        check(rdy_n, 1'b0, "cal ready");
    endtask
    initial begin
        repeat (5) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(negedge clock_i);
        check(rdy_n, 1'b1, "ready after reset");
        t_regs();
        push(16'h1234);
        host_port_model_i.frame(8'h30, 16, 16'hffff, rx);
        read_data(16'h1234);
        t_hold();
        t_fill();
        t_cal();
        test_done();
    end
    // Watchdog cuts a hang short
    initial begin
        #400us;
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
